/* design/cisr_pkg.sv */
// constants for the configuration, identification and sysref control bank
// assumes a 4-wire serial port with a 24-bit command header ahead of data bytes
package cisr_pkg;
   localparam int ADDR_W = 15;
   localparam int BYTE_W = 8;
   localparam int EDGE_W = 24;
   localparam int TAP_W = 4;
   localparam int FS_W = 16;

   // serial framing
   localparam logic [4:0] CMD_LAST = 5'h17;
   localparam logic [4:0] BYTE_LAST = 5'h07;
   localparam int CMD_RW_BIT = 23;

   // byte addresses
   localparam logic [14:0] ADR_SPI_CONFIG = 15'h0000;
   localparam logic [14:0] ADR_REVISION = 15'h0006;
   localparam logic [14:0] ADR_MAKER_LO = 15'h000c;
   localparam logic [14:0] ADR_MAKER_HI = 15'h000d;
   localparam logic [14:0] ADR_USER_CFG = 15'h0010;
   localparam logic [14:0] ADR_SYSREF_CTRL = 15'h0029;
   localparam logic [14:0] ADR_INPUT_FMT = 15'h002a;
   localparam logic [14:0] ADR_EDGE_0 = 15'h002c;
   localparam logic [14:0] ADR_EDGE_1 = 15'h002d;
   localparam logic [14:0] ADR_EDGE_2 = 15'h002e;
   localparam logic [14:0] ADR_FS_A_LO = 15'h0030;
   localparam logic [14:0] ADR_FS_A_HI = 15'h0031;
   localparam logic [14:0] ADR_FS_B_LO = 15'h0032;
   localparam logic [14:0] ADR_FS_B_HI = 15'h0033;
   localparam logic [14:0] ADR_REF_SEL = 15'h0038;
   localparam logic [14:0] ADR_TSTAMP = 15'h003b;
   localparam logic [14:0] ADR_STEP = 15'h0001;

   // reset values
   localparam logic [7:0] RST_USER_CFG = 8'h00;
   localparam logic [7:0] RST_SYSREF_CTRL = 8'h00;
   localparam logic [7:0] RST_INPUT_FMT = 8'h20;
   localparam logic [15:0] RST_FS = 16'ha000;
   localparam logic [7:0] RST_REF_SEL = 8'h00;
   localparam logic [7:0] RST_TSTAMP = 8'h00;
   localparam logic RST_DIR_UP = 1'b1;

   // field positions
   localparam int POS_DIR_UP = 5;
   localparam int POS_FOUR_WIRE = 4;
   localparam int POS_FREEZE = 0;
   localparam int POS_PROC_ON = 6;
   localparam int POS_RECV_ON = 5;
   localparam int POS_MAGNIFY = 4;
   localparam int POS_TAP_LSB = 0;
   localparam int POS_DEVICE_CLOCK_PECL = 2;
   localparam int POS_SYSREF_PECL = 1;
   localparam int POS_SYSREF_INV = 0;
   localparam logic [3:0] TAP_CALIBRATED = 4'h0;
endpackage

/* design/cisr_sync.sv */
// two-stage synchroniser with edge flags for a group of slow pins
// assumes each bit is independent and changes slower than the clock
`timescale 1ns/1ps
module cisr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in, // system clock
   input wire logic srst_in, // synchronous reset, high
   input wire logic [WIDTH-1:0] async_in, // pins from outside
   output logic [WIDTH-1:0] level_out, // synchronised level
   output logic [WIDTH-1:0] rise_out, // one-cycle rising flag
   output logic [WIDTH-1:0] fall_out // one-cycle falling flag
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   initial
   begin
      if (WIDTH < 1)
         $error("cisr_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_out = sync_q;
   assign rise_out = sync_q & ~prev_q;
   assign fall_out = ~sync_q & prev_q;
endmodule

/* design/cisr_regs.sv */
// serial-port register bank: identification, port setup, sysref and input control
// assumes the serial clock runs well below a quarter of CLK_IN; pins are oversampled
`timescale 1ns/1ps
module cisr_regs #(
   parameter logic [15:0] MAKER_CODE = 16'h1234, // arbitrary value
   parameter logic [7:0] SILICON_REV = 8'h5a // arbitrary value
) (
   input wire logic CLK_IN, // system clock, 100 MHz
   input wire logic SRST_IN, // synchronous reset, high
   input wire logic SPI_SCLK_IN, // serial clock pin
   input wire logic SPI_CS_N_IN, // chip select pin, low active
   input wire logic SPI_SDI_IN, // serial data in pin
   output logic SPI_SDO_OUT, // serial data out
   output logic SPI_SDO_OE_OUT, // high while driving serial data out
   input wire logic SYSREF_IN, // raw sysref level from receiver
   input wire logic [23:0] SYSREF_EDGE_STATUS_IN, // edge position from analog
   output logic SYSREF_EVENT_OUT, // one-cycle accepted sysref event
   output logic SYSREF_RECEIVER_ON_OUT, // sysref receiver enable
   output logic SYSREF_PROCESSOR_ON_OUT, // sysref processor enable
   output logic SYSREF_MAGNIFY_OUT, // finer edge status resolution
   output logic [3:0] SYSREF_DELAY_TAP_OUT, // selected delay tap
   output logic SYSREF_USE_CAL_OUT, // calibrated timing in use
   output logic SYSREF_PECL_OUT, // sysref receiver pecl mode
   output logic DEVICE_CLOCK_PECL_OUT, // device clock receiver pecl mode
   output logic [15:0] FULLSCALE_A_OUT, // input a full-scale setting
   output logic [15:0] FULLSCALE_B_OUT, // input b full-scale setting
   output logic [7:0] REFERENCE_SELECT_OUT, // reference source control byte
   output logic [7:0] TIMESTAMP_CTRL_OUT // timestamp input control byte
);
   typedef enum logic [1:0] {SPI_IDLE, SPI_CMD, SPI_DATA} cisr_phase_e;

   logic [3:0] pin_level;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;
   logic [23:0] edge_status;
   cisr_phase_e phase_q;
   logic [4:0] cnt_q;
   logic [23:0] shift_q;
   logic read_q;
   logic [14:0] addr_q;
   logic [7:0] rd_shift_q;
   logic sdo_q;
   logic dir_up_q;
   logic [7:0] user_cfg_q;
   logic [7:0] sysref_ctrl_q;
   logic [7:0] input_fmt_q;
   logic [15:0] fs_a_q;
   logic [15:0] fs_b_q;
   logic [7:0] ref_sel_q;
   logic [7:0] tstamp_q;
   logic sysref_prev_q;
   logic sysref_event_q;
   logic idle_seen_q;

   // pin group: sclk, cs_n, sdi, sysref
   cisr_sync #(.WIDTH(4)) u_pin_sync (
      .clk_in(CLK_IN),
      .srst_in(SRST_IN),
      .async_in({SYSREF_IN, SPI_SDI_IN, SPI_CS_N_IN, SPI_SCLK_IN}),
      .level_out(pin_level),
      .rise_out(pin_rise),
      .fall_out(pin_fall)
   );

   cisr_sync #(.WIDTH(cisr_pkg::EDGE_W)) u_edge_sync (
      .clk_in(CLK_IN),
      .srst_in(SRST_IN),
      .async_in(SYSREF_EDGE_STATUS_IN),
      .level_out(edge_status),
      .rise_out(),
      .fall_out()
   );

   wire sclk_rise = pin_rise[0];
   wire sclk_fall = pin_fall[0];
   wire cs_idle = pin_level[1];
   wire sdi = pin_level[2];
   wire sysref_lvl = pin_level[3];

   function automatic logic [7:0] rd_byte(input logic [14:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         cisr_pkg::ADR_SPI_CONFIG:
         begin
            r[cisr_pkg::POS_DIR_UP] = dir_up_q;
            r[cisr_pkg::POS_FOUR_WIRE] = 1'b1;
         end
         cisr_pkg::ADR_REVISION: r = SILICON_REV;
         cisr_pkg::ADR_MAKER_LO: r = MAKER_CODE[7:0];
         cisr_pkg::ADR_MAKER_HI: r = MAKER_CODE[15:8];
         cisr_pkg::ADR_USER_CFG: r = user_cfg_q;
         cisr_pkg::ADR_SYSREF_CTRL: r = sysref_ctrl_q;
         cisr_pkg::ADR_INPUT_FMT: r = input_fmt_q;
         cisr_pkg::ADR_EDGE_0: r = edge_status[7:0];
         cisr_pkg::ADR_EDGE_1: r = edge_status[15:8];
         cisr_pkg::ADR_EDGE_2: r = edge_status[23:16];
         cisr_pkg::ADR_FS_A_LO: r = fs_a_q[7:0];
         cisr_pkg::ADR_FS_A_HI: r = fs_a_q[15:8];
         cisr_pkg::ADR_FS_B_LO: r = fs_b_q[7:0];
         cisr_pkg::ADR_FS_B_HI: r = fs_b_q[15:8];
         cisr_pkg::ADR_REF_SEL: r = ref_sel_q;
         cisr_pkg::ADR_TSTAMP: r = tstamp_q;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // serial framing decode
   wire [23:0] shift_d = {shift_q[22:0], sdi};
   wire cmd_done = (phase_q == SPI_CMD) && sclk_rise && (cnt_q == cisr_pkg::CMD_LAST);
   wire byte_done = (phase_q == SPI_DATA) && sclk_rise && (cnt_q == cisr_pkg::BYTE_LAST);
   wire [14:0] cmd_addr = shift_d[cisr_pkg::ADDR_W-1:0];
   wire freeze = user_cfg_q[cisr_pkg::POS_FREEZE];
   wire [14:0] addr_up = addr_q + cisr_pkg::ADR_STEP;
   wire [14:0] addr_down = addr_q - cisr_pkg::ADR_STEP;
   wire [14:0] addr_dir = dir_up_q ? addr_up : addr_down;
   wire [14:0] addr_next = freeze ? addr_q : addr_dir;
   wire wr_fire = byte_done && !read_q;
   wire [7:0] wr_byte = shift_d[7:0];

   // write strobes; unlisted and read-only addresses match nothing
   wire wr_spi_cfg = wr_fire && (addr_q == cisr_pkg::ADR_SPI_CONFIG);
   wire wr_user = wr_fire && (addr_q == cisr_pkg::ADR_USER_CFG);
   wire wr_sysref = wr_fire && (addr_q == cisr_pkg::ADR_SYSREF_CTRL);
   wire wr_fmt = wr_fire && (addr_q == cisr_pkg::ADR_INPUT_FMT);
   wire wr_fs_a_lo = wr_fire && (addr_q == cisr_pkg::ADR_FS_A_LO);
   wire wr_fs_a_hi = wr_fire && (addr_q == cisr_pkg::ADR_FS_A_HI);
   wire wr_fs_b_lo = wr_fire && (addr_q == cisr_pkg::ADR_FS_B_LO);
   wire wr_fs_b_hi = wr_fire && (addr_q == cisr_pkg::ADR_FS_B_HI);
   wire wr_ref = wr_fire && (addr_q == cisr_pkg::ADR_REF_SEL);
   wire wr_tstamp = wr_fire && (addr_q == cisr_pkg::ADR_TSTAMP);

   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN || cs_idle)
      begin
         phase_q <= cs_idle ? SPI_IDLE : SPI_CMD;
         cnt_q <= 5'h00;
         shift_q <= 24'h000000;
      end
      else
      begin
         case (phase_q)
            SPI_IDLE:
            begin
               phase_q <= SPI_CMD;
               cnt_q <= 5'h00;
            end
            SPI_CMD,
            SPI_DATA:
            begin
               if (sclk_rise)
               begin
                  shift_q <= shift_d;
                  cnt_q <= (cmd_done || byte_done) ? 5'h00 : cnt_q + 5'h01;
                  if (cmd_done)
                     phase_q <= SPI_DATA;
               end
            end
            default: phase_q <= SPI_IDLE;
         endcase
      end
   end

   // address, read shifter and serial output
   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN || cs_idle)
      begin
         read_q <= 1'b0;
         addr_q <= 15'h0000;
         rd_shift_q <= 8'h00;
         sdo_q <= 1'b0;
      end
      else if (cmd_done)
      begin
         read_q <= shift_d[cisr_pkg::CMD_RW_BIT];
         addr_q <= cmd_addr;
         rd_shift_q <= rd_byte(cmd_addr);
      end
      else if (byte_done)
      begin
         addr_q <= addr_next;
         rd_shift_q <= rd_byte(addr_next);
      end
      else if ((phase_q == SPI_DATA) && sclk_fall && read_q)
      begin
         sdo_q <= rd_shift_q[7];
         rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
   end

   // writable registers
   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN)
      begin
         dir_up_q <= cisr_pkg::RST_DIR_UP;
         user_cfg_q <= cisr_pkg::RST_USER_CFG;
         sysref_ctrl_q <= cisr_pkg::RST_SYSREF_CTRL;
         input_fmt_q <= cisr_pkg::RST_INPUT_FMT;
      end
      else
      begin
         if (wr_spi_cfg)
            dir_up_q <= wr_byte[cisr_pkg::POS_DIR_UP];
         if (wr_user)
            user_cfg_q <= wr_byte;
         if (wr_sysref)
            sysref_ctrl_q <= wr_byte;
         if (wr_fmt)
            input_fmt_q <= wr_byte;
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN)
      begin
         fs_a_q <= cisr_pkg::RST_FS;
         fs_b_q <= cisr_pkg::RST_FS;
         ref_sel_q <= cisr_pkg::RST_REF_SEL;
         tstamp_q <= cisr_pkg::RST_TSTAMP;
      end
      else
      begin
         if (wr_fs_a_lo)
            fs_a_q[7:0] <= wr_byte;
         if (wr_fs_a_hi)
            fs_a_q[15:8] <= wr_byte;
         if (wr_fs_b_lo)
            fs_b_q[7:0] <= wr_byte;
         if (wr_fs_b_hi)
            fs_b_q[15:8] <= wr_byte;
         if (wr_ref)
            ref_sel_q <= wr_byte;
         if (wr_tstamp)
            tstamp_q <= wr_byte;
      end
   end

   // sysref path: optional inversion, rising edge, processor and receiver gate
   wire recv_on = sysref_ctrl_q[cisr_pkg::POS_RECV_ON];
   wire proc_on = sysref_ctrl_q[cisr_pkg::POS_PROC_ON];
   wire sysref_aligned = sysref_lvl ^ input_fmt_q[cisr_pkg::POS_SYSREF_INV];
   wire sysref_edge = sysref_aligned && !sysref_prev_q;

   always_ff @(posedge CLK_IN)
   begin
      if (SRST_IN)
      begin
         sysref_prev_q <= 1'b0;
         sysref_event_q <= 1'b0;
      end
      else
      begin
         sysref_prev_q <= sysref_aligned;
         sysref_event_q <= sysref_edge && proc_on && recv_on;
      end
   end

   // output stays off until select has been seen idle once after reset
   always_ff @(posedge CLK_IN)
      idle_seen_q <= SRST_IN ? 1'b0 : (idle_seen_q || cs_idle);

   wire [3:0] tap = sysref_ctrl_q[cisr_pkg::POS_TAP_LSB +: cisr_pkg::TAP_W];

   assign SPI_SDO_OUT = sdo_q;
   assign SPI_SDO_OE_OUT = !cs_idle && idle_seen_q;
   assign SYSREF_EVENT_OUT = sysref_event_q;
   assign SYSREF_RECEIVER_ON_OUT = recv_on;
   assign SYSREF_PROCESSOR_ON_OUT = proc_on;
   assign SYSREF_MAGNIFY_OUT = sysref_ctrl_q[cisr_pkg::POS_MAGNIFY];
   assign SYSREF_DELAY_TAP_OUT = tap;
   assign SYSREF_USE_CAL_OUT = (tap == cisr_pkg::TAP_CALIBRATED);
   assign SYSREF_PECL_OUT = input_fmt_q[cisr_pkg::POS_SYSREF_PECL];
   assign DEVICE_CLOCK_PECL_OUT = input_fmt_q[cisr_pkg::POS_DEVICE_CLOCK_PECL];
   assign FULLSCALE_A_OUT = fs_a_q;
   assign FULLSCALE_B_OUT = fs_b_q;
   assign REFERENCE_SELECT_OUT = ref_sel_q;
   assign TIMESTAMP_CTRL_OUT = tstamp_q;
endmodule

/* test/cisr_regs_sva.sv */
// assertions on the bank pins: sysref gating, tap decode, port enable, reset
// assumes binding onto cisr_regs by port name
`timescale 1ns/1ps
module cisr_regs_chk (
   input wire logic CLK_IN, // clock
   input wire logic SRST_IN, // reset
   input wire logic SPI_CS_N_IN, // select
   input wire logic SPI_SDO_OUT, // data out
   input wire logic SPI_SDO_OE_OUT, // out enable
   input wire logic SYSREF_IN, // sysref pin
   input wire logic SYSREF_EVENT_OUT, // event
   input wire logic SYSREF_RECEIVER_ON_OUT, // receiver
   input wire logic SYSREF_PROCESSOR_ON_OUT, // processor
   input wire logic [3:0] SYSREF_DELAY_TAP_OUT, // tap
   input wire logic SYSREF_USE_CAL_OUT, // calibrated
   input wire logic DEVICE_CLOCK_PECL_OUT // pecl
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SRST_IN);
   sequence cs_idle;
      SPI_CS_N_IN [*3];
   endsequence
   sequence cs_busy;
      !SPI_CS_N_IN [*3];
   endsequence
   sequence reset_held;
      SRST_IN [*3];
   endsequence
   chk_cal_decode: assert property (SYSREF_USE_CAL_OUT == (SYSREF_DELAY_TAP_OUT == 4'h0))
      else $error("calibrated flag disagrees with tap");
   chk_event_gate: assert property (SYSREF_EVENT_OUT |->
      $past(SYSREF_PROCESSOR_ON_OUT) && $past(SYSREF_RECEIVER_ON_OUT))
      else $error("sysref event while disabled");
   chk_event_pulse: assert property (SYSREF_EVENT_OUT |=> !SYSREF_EVENT_OUT)
      else $error("sysref event longer than one cycle");
   chk_event_cause: assert property (SYSREF_EVENT_OUT |->
      $past(SYSREF_IN, 3) != $past(SYSREF_IN, 6))
      else $error("sysref event without pin edge");
   chk_oe_idle: assert property (cs_idle |-> !SPI_SDO_OE_OUT)
      else $error("data out driven while deselected");
   chk_oe_busy: assert property (cs_busy |-> SPI_SDO_OE_OUT)
      else $error("data out not driven while selected");
   chk_sdo_quiet: assert property (SPI_CS_N_IN [*5] |-> !SPI_SDO_OUT)
      else $error("data out not low outside frames");
   chk_ctrl_framed: assert property (!$stable({SYSREF_PROCESSOR_ON_OUT,
      SYSREF_RECEIVER_ON_OUT, SYSREF_DELAY_TAP_OUT, DEVICE_CLOCK_PECL_OUT}) |->
      !$past(SPI_CS_N_IN, 3))
      else $error("control bits changed outside a frame");
   chk_reset_vals: assert property (disable iff (1'b0) reset_held |=>
      !SYSREF_PROCESSOR_ON_OUT && !SYSREF_RECEIVER_ON_OUT && !DEVICE_CLOCK_PECL_OUT &&
      SYSREF_DELAY_TAP_OUT == 4'h0 && !SYSREF_EVENT_OUT)
      else $error("control bits not at reset values");
endmodule
bind cisr_regs cisr_regs_chk u_chk (.*);

/* test/cisr_host_model.sv */
// serial host model: drives select, clock and data, shifts read bytes in
// assumes the system clock runs at least twelve times the serial rate
`timescale 1ns/1ps
module cisr_host_model (
   input wire logic clk_in, // system clock
   input wire logic sdo_in, // device data out
   output logic sclk_out, // serial clock
   output logic cs_n_out, // select, low active
   output logic sdi_out, // data to device
   output logic [7:0] rd_byte_out, // last byte read
   output logic rd_strobe_out // one-cycle byte flag
);
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      sdi_out = 1'b0;
      rd_byte_out = 8'h00;
      rd_strobe_out = 1'b0;
   end
   // released data line toggles so a stale bit never looks valid
   always @(posedge clk_in)
      if (cs_n_out)
         sdi_out <= ~sdi_out;
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic bit_cycle(input logic b, inout logic [7:0] sh);
      sclk_out = 1'b0;
      sdi_out = b;
      wait_n(6);
      sh = {sh[6:0], sdo_in};
      sclk_out = 1'b1;
      wait_n(6);
   endtask
   task automatic xfer(input logic rd, input logic [14:0] adr, input logic [7:0] wd[$]);
      logic [23:0] cmd;
      logic [7:0] sh;
      cmd = {rd, 8'h00, adr};
      sh = 8'h00;
      wait_n(6);
      cs_n_out = 1'b0;
      for (int i = 23; i >= 0; i--)
         bit_cycle(cmd[i], sh);
      foreach (wd[k])
      begin
         for (int i = 7; i >= 0; i--)
            bit_cycle(wd[k][i], sh);
         rd_byte_out = sh;
         rd_strobe_out = rd;
         wait_n(1);
         rd_strobe_out = 1'b0;
      end
      sclk_out = 1'b0;
      wait_n(6);
      cs_n_out = 1'b1;
   endtask
endmodule

/* test/cisr_regs_bench.sv */
// self-checking bench for the register bank, driven through the serial host model
// assumes the checker is bound onto the bank by its own file
`timescale 1ns/1ps
module cisr_regs_bench;
   localparam logic [15:0] MAKER = 16'h3c5a; // arbitrary value
   localparam logic [7:0] REV = 8'h6e; // arbitrary value
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sysref = 1'b0;
   logic [23:0] edge_st = 24'h000000;
   logic sclk, cs_n, sdi, sdo, rd_stb, ev, recv, proc, mag, use_cal, dpecl, specl;
   logic [3:0] tap;
   logic oe;
   // released data-out line reads inverted so a stale bit never looks valid
   wire sdo_line = oe ? sdo : !sdo;
   logic [7:0] rd_byte, ref_sel, tstamp;
   logic [15:0] fs_a, fs_b;
   logic [7:0] b[3];
   logic [7:0] exp_q[$];
   logic [31:0] lfsr_st = 32'h4fa2;
   int n_mismatch = 0;
   int tests_run = 0;
   int n_event = 0;
   always #5 clk = ~clk;
   cisr_host_model host (.clk_in(clk), .sdo_in(sdo_line), .sclk_out(sclk), .cs_n_out(cs_n),
      .sdi_out(sdi), .rd_byte_out(rd_byte), .rd_strobe_out(rd_stb));
   cisr_regs #(.MAKER_CODE(MAKER), .SILICON_REV(REV)) DUT (.CLK_IN(clk), .SRST_IN(srst),
      .SPI_SCLK_IN(sclk), .SPI_CS_N_IN(cs_n), .SPI_SDI_IN(sdi), .SPI_SDO_OUT(sdo),
      .SPI_SDO_OE_OUT(oe), .SYSREF_IN(sysref), .SYSREF_EDGE_STATUS_IN(edge_st),
      .SYSREF_EVENT_OUT(ev), .SYSREF_RECEIVER_ON_OUT(recv), .SYSREF_PROCESSOR_ON_OUT(proc),
      .SYSREF_MAGNIFY_OUT(mag), .SYSREF_DELAY_TAP_OUT(tap), .SYSREF_USE_CAL_OUT(use_cal),
      .SYSREF_PECL_OUT(specl), .DEVICE_CLOCK_PECL_OUT(dpecl), .FULLSCALE_A_OUT(fs_a),
      .FULLSCALE_B_OUT(fs_b), .REFERENCE_SELECT_OUT(ref_sel), .TIMESTAMP_CTRL_OUT(tstamp));
   function automatic logic [7:0] rnd();
      repeat (8) lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
      return lfsr_st[7:0];
   endfunction
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d[$]);
      host.xfer(1'b0, a, d);
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e[$]);
      foreach (e[k])
         exp_q.push_back(e[k]);
      host.xfer(1'b1, a, e);
   endtask
   task automatic pulse(input int n_exp);
      sysref = 1'b1;
      repeat (8) @(negedge clk);
      sysref = 1'b0;
      repeat (8) @(negedge clk);
      check("sysref events", n_event, n_exp);
   endtask
   task automatic do_reset();
      srst = 1'b1;
      repeat (12) @(negedge clk);
      srst = 1'b0;
      repeat (6) @(negedge clk);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // result watcher: each read byte is matched against the oldest note
   always @(posedge clk)
   begin
      if (ev)
         n_event <= n_event + 1;
      if (rd_stb)
         check("read byte", rd_byte, exp_q.size() ? exp_q.pop_front() : 9'h1ff);
   end
   initial
   begin
      do_reset();
      check("calibrated after reset", use_cal, 1'b1);
      rd(15'h000, '{8'h30});
      rd(15'h030, '{8'h00, 8'ha0, 8'h00, 8'ha0});
      rd(15'h029, '{8'h00, 8'h20});
      wr(15'h00c, '{8'hff, 8'hff});
      wr(15'h006, '{8'hff});
      rd(15'h00c, '{MAKER[7:0], MAKER[15:8]});
      rd(15'h006, '{REV});
      wr(15'h02b, '{rnd()});
      wr(15'h034, '{rnd(), rnd(), rnd(), rnd()});
      rd(15'h029, '{8'h00, 8'h20});
      check("fullscale a", fs_a, 16'ha000);
      pulse(0);
      wr(15'h029, '{8'h20});
      check("receiver", {recv, proc}, 2'b10);
      pulse(0);
      wr(15'h029, '{8'h60});
      pulse(1);
      pulse(2);
      for (int t = 0; t < 16; t++)
      begin
         edge_st = {rnd(), rnd(), rnd()};
         edge_st[3:0] = t[3:0];
         repeat (4) @(negedge clk);
         rd(15'h02c, '{edge_st[7:0], edge_st[15:8], edge_st[23:16]});
         wr(15'h029, '{{1'b0, 2'b11, t[0], edge_st[3:0]}});
         check("magnify", mag, t[0]);
         check("tap", tap, edge_st[3:0]);
         check("calibrated", use_cal, edge_st[3:0] == 4'h0);
      end
      wr(15'h02a, '{8'h24});
      check("pecl modes", {dpecl, specl}, 2'b10);
      // inversion switched with the processor off, then a falling pin edge is the event
      wr(15'h029, '{8'h20});
      wr(15'h02a, '{8'h25});
      wr(15'h029, '{8'h60});
      pulse(3);
      b = '{rnd(), rnd(), rnd()};
      wr(15'h010, '{8'h01});
      wr(15'h038, '{b[0], b[1], b[2]});
      check("frozen target", {ref_sel, tstamp}, {b[2], 8'h00});
      rd(15'h038, '{b[2], b[2]});
      wr(15'h010, '{8'h00});
      rd(15'h038, '{b[2], 8'h00, 8'h00, 8'h00});
      wr(15'h000, '{8'h00});
      wr(15'h033, '{b[0], b[1], b[2], b[0]});
      check("descending", {fs_a, fs_b}, {b[2], b[0], b[0], b[1]});
      do_reset();
      check("second reset", {dpecl, proc, tap, fs_a}, {6'h00, 16'ha000});
      rd(15'h000, '{8'h30});
      for (int i = 0; i < 1000 && exp_q.size() != 0; i++)
         @(negedge clk);
      check("pending reads", exp_q.size(), 0);
      results();
   end
endmodule
